// File: src/coc_pkg.sv
// Constants, mode enumeration and config carrier for the comparator output conditioner.
// Operation
// RL1 - Filter clock: internal divider or external strobe.
// RL2 - Agree count programmable; one means plain sampler.
// RL3 - External mode samples on strobe rising edges.
// RL4 - Window mode passes result only while gate high.
// RL5 - Comparator off: disabled, result reads zero.
// RL6 - Continuous mode decode conditions.
// RL7 - Continuous mode bypasses window and filter.
// RL8 - Continuous: filtered output equals raw output.
// RL9 - Continuous: optional invert, no sampling or filtering.
// RL10 - Sampled unfiltered mode decode, variants A and B.
// RL11 - Sampled modes capture raw output on filter clock.
// RL12 - Variant B unfiltered only samples and holds.
// RL13 - Sampled filtered mode decode; count enables filtering.
// RL14 - Windowed mode captures every clock while gate high.
// RL15 - Windowed resampled mode uses sample period.
// RL16 - Windowed filtered mode resamples and filters.
// RL17 - Fault-input use requires continuous mode.
// RL18 - Clear strobe enable and count before changes.
// RL19 - Unlisted setting combinations are undefined.
// RL20 - Window mode holds raw value while gate low.
// RL21 - Output changes after count consecutive agreeing samples.
// RL22 - Filter output starts at zero.
// RL23 - Rising and falling edges set sticky flags.
package coc_pkg;
   // Register offsets on the plain register port.
   localparam logic [1:0] OFS_CTRL0 = 2'h0;
   localparam logic [1:0] OFS_CTRL1 = 2'h1;
   localparam logic [1:0] OFS_PERIOD = 2'h2;
   localparam logic [1:0] OFS_FLAGS = 2'h3;
   // Field positions in control_reg_one.
   localparam int CTRL1_ON_BIT = 0;
   localparam int CTRL1_INV_BIT = 1;
   localparam int CTRL1_WIN_BIT = 2;
   localparam int CTRL1_EXT_BIT = 3;
   // Field positions in flag_reg.
   localparam int FLAGS_OUT_BIT = 0;
   localparam int FLAGS_FALL_BIT = 1;
   localparam int FLAGS_RISE_BIT = 2;
   // Reset values.
   localparam logic [2:0] CTRL0_RST = 3'h0;
   localparam logic [3:0] CTRL1_RST = 4'h0;
   localparam logic [7:0] PERIOD_RST = 8'h00;
   // Operating modes.
   typedef enum logic [2:0] {
      MODE_OFF, MODE_CONT, MODE_SAMP_EXT, MODE_SAMP_INT,
      MODE_WIN, MODE_WIN_SAMP, MODE_ILLEGAL
   } coc_mode_t;
   // Configuration carrier.
   typedef struct packed {
      logic comparator_on;
      logic invert_select;
      logic window_enable;
      logic ext_sample_enable;
      logic [2:0] sample_agree_count;
      logic [7:0] sample_period;
   } coc_cfg_t;
endpackage

// File: src/coc_top.sv
// Digital conditioning path behind an analog voltage comparator.
//
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/1ns
module coc_top (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Register port.
   input wire logic [1:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   // Comparator and gate/strobe sources.
   input wire logic cmp_analog_in,
   input wire logic window_in,
   input wire logic sample_in,
   // Conditioned outputs.
   output logic raw_output_out,
   output logic filtered_output_out
);

   // Registered configuration.
   logic [2:0] ctrl0_q, ctrl0_d;
   logic [3:0] ctrl1_q, ctrl1_d;
   logic [7:0] period_q, period_d;
   logic [7:0] rdata_q, rdata_d;
   coc_pkg::coc_cfg_t cfg;
   coc_pkg::coc_mode_t mode;

   // Datapath state.
   logic win_q, win_d; // Latched windowed value.
   logic strobe_q, strobe_d; // Previous strobe level.
   logic [7:0] div_q, div_d; // Internal divider.
   logic [3:0] agree_q, agree_d; // Consecutive disagreeing samples.
   logic filt_q, filt_d; // Filter output.
   logic prev_q, prev_d; // Previous output for edge detect.
   logic rise_q, rise_d;
   logic fall_q, fall_d;
   logic [7:0] gap_q, gap_d; // Checker helper: cycles since the last internal tick.

   // Combinational terms.
   logic compare_result;
   logic raw_output;
   logic windowed;
   logic filt_active;
   logic tick;
   logic sample;

   // Decode the operating mode from the settings.
   // Unlisted combinations fall into the illegal state, which keeps the filter cleared,
   // so a bad setting shows a steady zero at the filtered output instead of stray filtered edges.
   function automatic coc_pkg::coc_mode_t decode(input coc_pkg::coc_cfg_t c);
      logic zero_cfg;
      zero_cfg = (c.sample_agree_count == 3'h0) || (c.sample_period == 8'h00);
      if (!c.comparator_on) begin
         decode = coc_pkg::MODE_OFF; // RL5
      end else if (!c.window_enable && !c.ext_sample_enable && zero_cfg) begin
         decode = coc_pkg::MODE_CONT; // RL6
      end else if (!c.window_enable && c.ext_sample_enable &&
                   c.sample_agree_count != 3'h0) begin
         decode = coc_pkg::MODE_SAMP_EXT; // RL10 RL13
      end else if (!c.window_enable && !c.ext_sample_enable) begin
         decode = coc_pkg::MODE_SAMP_INT; // RL10 RL13
      end else if (c.window_enable && !c.ext_sample_enable && zero_cfg) begin
         decode = coc_pkg::MODE_WIN; // RL14
      end else if (c.window_enable && !c.ext_sample_enable) begin
         decode = coc_pkg::MODE_WIN_SAMP; // RL15 RL16
      end else begin
         decode = coc_pkg::MODE_ILLEGAL;
      end
   endfunction

   // Gather the configuration and decode the mode.
   always_comb begin
      cfg.comparator_on = ctrl1_q[coc_pkg::CTRL1_ON_BIT];
      cfg.invert_select = ctrl1_q[coc_pkg::CTRL1_INV_BIT];
      cfg.window_enable = ctrl1_q[coc_pkg::CTRL1_WIN_BIT];
      cfg.ext_sample_enable = ctrl1_q[coc_pkg::CTRL1_EXT_BIT];
      cfg.sample_agree_count = ctrl0_q;
      cfg.sample_period = period_q;
      mode = decode(cfg);
   end

   // Comparator result, window stage and output selection.
   // Continuous mode stays a pure gate path so a fault reaches the timer at once.
   always_comb begin
      compare_result = cfg.comparator_on & (cmp_analog_in ^ cfg.invert_select); // RL5 RL9
      windowed = (mode == coc_pkg::MODE_WIN) || (mode == coc_pkg::MODE_WIN_SAMP);
      filt_active = (mode == coc_pkg::MODE_SAMP_EXT) ||
                    (mode == coc_pkg::MODE_SAMP_INT) || (mode == coc_pkg::MODE_WIN_SAMP);
      raw_output = windowed ? win_q : compare_result; // RL4
      case (mode)
         coc_pkg::MODE_OFF: filtered_output_out = 1'b0;
         coc_pkg::MODE_CONT: filtered_output_out = raw_output; // RL7 RL8
         coc_pkg::MODE_WIN: filtered_output_out = win_q;
         default: filtered_output_out = filt_q;
      endcase
      raw_output_out = raw_output;
   end

   // Sample tick: strobe rising edge or divider wrap.
   // The divider restarts from zero whenever the internal modes are left, so the first
   // internal sample lands a full period after the settings take effect.
   always_comb begin
      strobe_d = sample_in;
      div_d = 8'h00;
      tick = 1'b0;
      if (mode == coc_pkg::MODE_SAMP_EXT) begin
         tick = sample_in & ~strobe_q; // RL1 RL3
      end else if (filt_active) begin
         tick = (div_q == period_q - 8'h01); // RL1 RL11
         div_d = tick ? 8'h00 : div_q + 8'h01;
      end
   end

   // Window latch: follows the result while the gate is high, else holds.
   // The latch is not cleared when windowing is left; a later windowed mode shows
   // that stale value until the gate opens once.
   always_comb begin
      win_d = win_q;
      if (windowed && window_in) begin
         win_d = compare_result; // RL14 RL20
      end
   end

   // Agreement filter. A count of one makes every tick a plain sample.
   // Leaving the sampled modes clears it, which is the known restart state.
   always_comb begin
      sample = raw_output;
      filt_d = filt_q;
      agree_d = agree_q;
      if (!filt_active) begin
         filt_d = 1'b0; // RL18 RL22
         agree_d = 4'h0;
      end else if (tick) begin
         if (sample == filt_q) begin
            agree_d = 4'h0;
         end else if (agree_q + 4'h1 >= {1'b0, ctrl0_q}) begin
            filt_d = sample; // RL2 RL12 RL21
            agree_d = 4'h0;
         end else begin
            agree_d = agree_q + 4'h1; // RL21
         end
      end
   end

   // Checker helper: counts cycles between internal ticks apart from the divider,
   // so the period check does not lean on the very counter that it watches.
   always_comb begin
      gap_d = 8'h00;
      if (filt_active && mode != coc_pkg::MODE_SAMP_EXT && !tick) begin
         gap_d = gap_q + 8'h01;
      end
   end

   // Edge flags on the output; a new edge wins over a software clear.
   // Watching the conditioned output keeps glitches that the filter rejects
   // out of the flags.
   always_comb begin
      logic clr;
      clr = wr_in && (addr_in == coc_pkg::OFS_FLAGS);
      prev_d = filtered_output_out;
      rise_d = rise_q;
      fall_d = fall_q;
      if (clr && wdata_in[coc_pkg::FLAGS_RISE_BIT]) begin
         rise_d = 1'b0;
      end
      if (clr && wdata_in[coc_pkg::FLAGS_FALL_BIT]) begin
         fall_d = 1'b0;
      end
      if (filtered_output_out && !prev_q) begin
         rise_d = 1'b1; // RL23
      end
      if (!filtered_output_out && prev_q) begin
         fall_d = 1'b1; // RL23
      end
   end

   // Register writes and read data for the next cycle.
   // Read data is zero in every cycle after one without a read strobe, which keeps
   // the return path quiet when several slaves share it.
   always_comb begin
      ctrl0_d = ctrl0_q;
      ctrl1_d = ctrl1_q;
      period_d = period_q;
      rdata_d = 8'h00;
      if (wr_in) begin
         case (addr_in)
            coc_pkg::OFS_CTRL0: ctrl0_d = wdata_in[2:0];
            coc_pkg::OFS_CTRL1: ctrl1_d = wdata_in[3:0];
            coc_pkg::OFS_PERIOD: period_d = wdata_in;
            default: ;
         endcase
      end
      if (rd_in) begin
         case (addr_in)
            coc_pkg::OFS_CTRL0: rdata_d = {5'h00, ctrl0_q};
            coc_pkg::OFS_CTRL1: rdata_d = {4'h0, ctrl1_q};
            coc_pkg::OFS_PERIOD: rdata_d = period_q;
            default: rdata_d = {5'h00, rise_q, fall_q, filtered_output_out};
         endcase
      end
   end

   assign rdata_out = rdata_q;

   // State registers.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctrl0_q <= coc_pkg::CTRL0_RST;
         ctrl1_q <= coc_pkg::CTRL1_RST;
         period_q <= coc_pkg::PERIOD_RST;
         rdata_q <= 8'h00;
         win_q <= 1'b0;
         strobe_q <= 1'b0;
         div_q <= 8'h00;
         agree_q <= 4'h0;
         filt_q <= 1'b0;
         prev_q <= 1'b0;
         rise_q <= 1'b0;
         fall_q <= 1'b0;
         gap_q <= 8'h00;
      end else begin
         ctrl0_q <= ctrl0_d;
         ctrl1_q <= ctrl1_d;
         period_q <= period_d;
         rdata_q <= rdata_d;
         win_q <= win_d;
         strobe_q <= strobe_d;
         div_q <= div_d;
         agree_q <= agree_d;
         filt_q <= filt_d;
         prev_q <= prev_d;
         rise_q <= rise_d;
         fall_q <= fall_d;
         gap_q <= gap_d;
      end
   end

   // Checks on the conditioning path.
   // They watch the block's own outputs and state; the stimulus is judged elsewhere.
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   a_off_result_zero: assert property (mode == coc_pkg::MODE_OFF |-> // RL5
      compare_result == 1'b0 && filtered_output_out == 1'b0)
      else $error("result not zero while off");

   a_cont_pass_through: assert property (mode == coc_pkg::MODE_CONT |-> // RL8
      filtered_output_out == raw_output_out &&
      raw_output_out == (cmp_analog_in ^ cfg.invert_select))
      else $error("continuous path not direct");

   a_win_hold_low: assert property ((windowed && !window_in) ##1 windowed |-> // RL20
      win_q == $past(win_q))
      else $error("window latch moved while gate low");

   a_win_capture_high: assert property (windowed && window_in |=> // RL14
      win_q == $past(compare_result))
      else $error("window latch missed sample");

   a_ext_edge_tick: assert property ((mode == coc_pkg::MODE_SAMP_EXT) && // RL3
      $rose(sample_in) && !filt_q && raw_output && ctrl0_q == 3'h1 ##1
      (mode == coc_pkg::MODE_SAMP_EXT) |-> filt_q)
      else $error("strobe edge did not sample");

   a_int_period: assert property ((mode == coc_pkg::MODE_SAMP_INT || // RL11
      mode == coc_pkg::MODE_WIN_SAMP) |->
      tick == (gap_q == period_q - 8'h01))
      else $error("divider tick off period");

   a_filter_init_zero: assert property (!filt_active |=> filt_q == 1'b0) // RL22
      else $error("filter not cleared");

   a_filter_agree: assert property ($changed(filt_q) && $past(filt_active) |-> // RL21
      $past(tick) && ($past(agree_q) + 4'h1 >= {1'b0, $past(ctrl0_q)}))
      else $error("filter changed without agreement");

   a_rise_flag_set: assert property (filtered_output_out && !prev_q |=> rise_q) // RL23
      else $error("rise flag not set");

   a_fall_flag_set: assert property (!filtered_output_out && prev_q |=> fall_q) // RL23
      else $error("fall flag not set");

   a_filter_hold: assert property (filt_active && !tick |=> $stable(filt_q)) // RL12
      else $error("filter moved between samples");

   a_ext_no_edge: assert property (mode == coc_pkg::MODE_SAMP_EXT && // RL3
      !$rose(sample_in) |=> $stable(filt_q))
      else $error("filter moved without a strobe edge");

   a_win_gate_hold: assert property (mode == coc_pkg::MODE_WIN && !window_in ##1 // RL4
      mode == coc_pkg::MODE_WIN |-> $stable(filtered_output_out))
      else $error("windowed output moved while gate low");

   a_rise_clear: assert property (wr_in && addr_in == coc_pkg::OFS_FLAGS && // RL23
      wdata_in[coc_pkg::FLAGS_RISE_BIT] && !(filtered_output_out && !prev_q) |=> !rise_q)
      else $error("rise flag survived a clear");

   a_fall_clear: assert property (wr_in && addr_in == coc_pkg::OFS_FLAGS && // RL23
      wdata_in[coc_pkg::FLAGS_FALL_BIT] && !(!filtered_output_out && prev_q) |=> !fall_q)
      else $error("fall flag survived a clear");

endmodule

// File: bench/coc_src.sv
// Behavioural comparator result with window gate and sample strobe sources.
`timescale 1ns/1ns
module coc_src (
   // Clock.
   input wire logic clk_in,
   // Lines seen by the block.
   output logic cmp_out,
   output logic win_out,
   output logic smp_out
);
   // Everything starts low, so the block sees a quiet source.
   initial begin
      cmp_out = 1'b0;
      win_out = 1'b0;
      smp_out = 1'b0;
   end
   // Result and gate move just after an edge, as a synchronous source would.
   task automatic set(input logic c, input logic w);
      @(posedge clk_in);
      cmp_out <= c;
      win_out <= w;
   endtask
   // The strobe idles low and rises for one cycle per sample.
   task automatic pulse();
      @(posedge clk_in);
      smp_out <= 1'b1;
      @(posedge clk_in);
      smp_out <= 1'b0;
   endtask
endmodule

// File: bench/coc_top_tb.sv
// Self-checking bench for the comparator output conditioner.
`timescale 1ns/1ns
module coc_top_tb;
   logic clk_in = 1'b0; // Bus clock.
   logic rst_n_in = 1'b0; // Reset, active low.
   logic [1:0] addr_in = 2'h0; // Register port.
   logic [7:0] wdata_in = 8'h00;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic [7:0] rdata_out;
   logic cmp_w; // Source lines.
   logic win_w;
   logic smp_w;
   logic raw_output_out; // Outputs.
   logic filtered_output_out;
   int bad_count = 0;
   int cmp_count = 0;
   // Free-running 100 MHz clock.
   always #5 clk_in = ~clk_in;
   coc_src src (.clk_in(clk_in), .cmp_out(cmp_w), .win_out(win_w), .smp_out(smp_w));
   coc_top dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .cmp_analog_in(cmp_w), .window_in(win_w), .sample_in(smp_w),
      .raw_output_out(raw_output_out), .filtered_output_out(filtered_output_out));
   // Byte and bit comparisons; four-state so an unknown never matches.
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk8({7'h00, got}, {7'h00, exp});
   endtask
   // One-cycle write strobe.
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   // Read data is looked at in the one cycle where it stands.
   task automatic rd(input logic [1:0] a, input logic [7:0] exp);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      @(negedge clk_in);
      chk8(rdata_out, exp);
   endtask
   // Settings always pass through continuous mode, which clears the filter.
   task automatic cfg(input logic [7:0] c1, input logic [7:0] c0, input logic [7:0] per);
      wr(2'h1, 8'h01);
      wr(2'h0, 8'h00);
      wr(2'h2, per);
      wr(2'h1, c1);
      wr(2'h0, c0);
   endtask
   // Bounded wait for the conditioned output, then a comparison.
   task automatic wait_out(input logic v, input int n);
      for (int i = 0; i < n; i++) begin
         @(negedge clk_in);
         if (filtered_output_out === v) begin
            break;
         end
      end
      chk1(filtered_output_out, v);
   endtask
   // Reset values, then the disabled mode with a busy source.
   task automatic t_off();
      for (int a = 0; a < 4; a++) rd(a[1:0], 8'h00);
      src.set(1'b1, 1'b1);
      @(negedge clk_in);
      chk1(raw_output_out, 1'b0);
      chk1(filtered_output_out, 1'b0);
   endtask
   // Continuous mode in both decodes, plain and inverted.
   task automatic t_cont();
      cfg(8'h01, 8'h00, 8'h05);
      wr(2'h3, 8'h06);
      src.set(1'b0, 1'b0);
      @(negedge clk_in);
      chk1(filtered_output_out, 1'b0);
      src.set(1'b1, 1'b0);
      @(negedge clk_in);
      chk1(raw_output_out, 1'b1);
      chk1(filtered_output_out, 1'b1);
      rd(2'h3, 8'h07);
      cfg(8'h03, 8'h03, 8'h00);
      @(negedge clk_in);
      chk1(filtered_output_out, 1'b0);
      src.set(1'b0, 1'b0);
      @(negedge clk_in);
      chk1(raw_output_out, 1'b1);
   endtask
   // Internal divider: sampler, then a two-sample filter with a glitch.
   task automatic t_filt();
      cfg(8'h01, 8'h01, 8'h03);
      src.set(1'b1, 1'b0);
      wait_out(1'b1, 6);
      src.set(1'b0, 1'b0);
      cfg(8'h01, 8'h02, 8'h01);
      src.set(1'b1, 1'b0);
      @(negedge clk_in);
      chk1(filtered_output_out, 1'b0);
      wait_out(1'b1, 5);
      src.set(1'b0, 1'b0);
      src.set(1'b1, 1'b0);
      repeat (4) @(negedge clk_in);
      chk1(filtered_output_out, 1'b1);
      wr(2'h3, 8'h06);
      src.set(1'b0, 1'b0);
      wait_out(1'b0, 5);
      rd(2'h3, 8'h02);
   endtask
   // External strobe: only rising strobe edges take samples.
   task automatic t_ext();
      cfg(8'h09, 8'h01, 8'h00);
      src.set(1'b1, 1'b0);
      repeat (10) @(negedge clk_in);
      chk1(filtered_output_out, 1'b0);
      src.pulse();
      wait_out(1'b1, 4);
      cfg(8'h09, 8'h03, 8'h00);
      src.pulse();
      src.pulse();
      repeat (3) @(negedge clk_in);
      chk1(filtered_output_out, 1'b0);
      src.pulse();
      wait_out(1'b1, 4);
   endtask
   // Window gate: capture while open, hold while closed, then resampling.
   task automatic t_win();
      cfg(8'h05, 8'h00, 8'h00);
      src.set(1'b1, 1'b1);
      repeat (2) @(negedge clk_in);
      chk1(raw_output_out, 1'b1);
      src.set(1'b0, 1'b0);
      repeat (5) @(negedge clk_in);
      chk1(raw_output_out, 1'b1);
      src.set(1'b0, 1'b1);
      repeat (2) @(negedge clk_in);
      chk1(raw_output_out, 1'b0);
      cfg(8'h05, 8'h01, 8'h04);
      src.set(1'b1, 1'b1);
      wait_out(1'b1, 8);
      cfg(8'h05, 8'h03, 8'h02);
      @(negedge clk_in);
      chk1(filtered_output_out, 1'b0);
      wait_out(1'b1, 12);
      rd(2'h0, 8'h03);
      rd(2'h1, 8'h05);
      rd(2'h2, 8'h02);
   endtask
   // Verdict and end of run.
   task automatic summarize();
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Main sequence after a 16-cycle reset.
   initial begin
      repeat (16) @(posedge clk_in);
      rst_n_in <= 1'b1;
      t_off();
      t_cont();
      t_filt();
      t_ext();
      t_win();
      summarize();
   end
   // Watchdog well beyond the roughly 190 cycles the tests need.
   initial begin
      #100000;
      bad_count++;
      summarize();
   end
endmodule
